// ---- hw/usi_pkg.sv ----
// Package for the UART status and interrupt identification block.
// Assumes a byte-wide register port with full 32-bit byte addresses.
package usi_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_TX_RX = 32'hffff0700;
  localparam logic [31:0] ADDR_IRQ_EN = 32'hffff0704;
  localparam logic [31:0] ADDR_IRQ_ID = 32'hffff0708;
  localparam logic [31:0] ADDR_LINE_CTRL = 32'hffff070c;
  localparam logic [31:0] ADDR_LINE_STAT = 32'hffff0714;
  localparam logic [31:0] ADDR_EVT_STAT = 32'hffff0740;
  localparam logic [31:0] ADDR_EVT_MASK = 32'hffff0744;

  // ----------------------------------------------------------------
  // Line status field positions
  // ----------------------------------------------------------------
  localparam int LS_TX_ALL_EMPTY = 6;
  localparam int LS_TX_HOLD_EMPTY = 5;
  localparam int LS_BREAK = 4;
  localparam int LS_FRAMING = 3;
  localparam int LS_PARITY = 2;
  localparam int LS_OVERRUN = 1;
  localparam int LS_RX_READY = 0;

  // ----------------------------------------------------------------
  // Interrupt enable and line control fields
  // ----------------------------------------------------------------
  localparam int IE_LINE_STATUS = 2;
  localparam int IE_TX_EMPTY = 1;
  localparam int IE_RX_FULL = 0;
  localparam logic [7:0] IE_WRITE_MASK = 8'h07;
  localparam int LC_DIV_ACCESS = 7;

  // ----------------------------------------------------------------
  // Event status bits for the interrupt output
  // ----------------------------------------------------------------
  localparam int EV_WIDTH = 4;
  localparam int EV_RX_CHAR = 0;
  localparam int EV_TX_EMPTY = 1;
  localparam int EV_LINE_ERR = 2;
  localparam int EV_BREAK = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] IRQ_ID_RST = 8'h01;
  localparam logic [7:0] LINE_STAT_RST = 8'h60;
  localparam logic [3:0] EVT_RST = 4'h0;

  // ----------------------------------------------------------------
  // Timing: longest frame in bit times (start, 8 data, parity, 2 stop)
  // ----------------------------------------------------------------
  localparam int MAX_WORD_BITS = 12;

  // Identification codes in priority order, line status highest
  typedef enum logic [1:0] {
    IID_NONE = 2'b00,
    IID_TX_EMPTY = 2'b01,
    IID_RX_FULL = 2'b10,
    IID_LINE = 2'b11
  } usi_iid_t;

endpackage

// ---- hw/usi_break_det.sv ----
// Break detector: flags a serial input held low past the longest frame.
// Assumes bit_tick pulses once per bit time, synchronous to clk.
`timescale 1ns/1ns
module usi_break_det #(
  parameter int MAX_BITS = usi_pkg::MAX_WORD_BITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Line
  input wire logic serial_input,
  input wire logic bit_tick,
  // Result
  output logic break_pulse
);

  logic [4:0] low_cnt_reg;
  logic fired_reg;

  // Count bit times while low; one pulse per low stretch so a long
  // break is reported once, not once per frame time
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      low_cnt_reg <= 5'h00;
      fired_reg <= 1'b0;
      break_pulse <= 1'b0;
    end
    else if (serial_input)
    begin
      low_cnt_reg <= 5'h00;
      fired_reg <= 1'b0;
      break_pulse <= 1'b0;
    end
    else if (bit_tick && !fired_reg)
    begin
      if (low_cnt_reg == 5'(MAX_BITS))
      begin
        fired_reg <= 1'b1;
        break_pulse <= 1'b1;
      end
      else
      begin
        low_cnt_reg <= low_cnt_reg + 5'h01;
        break_pulse <= 1'b0;
      end
    end
    else
    begin
      break_pulse <= 1'b0;
    end
  end

endmodule

// ---- hw/usi_top.sv ----
// UART line status, interrupt enable and interrupt identification.
// Assumes the transmitter and receiver report events as one-cycle
// pulses and that the transmit shift register reads empty at reset.
`timescale 1ns/1ns

module usi_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [31:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Transmitter side
  output logic [7:0] tx_data,
  output logic tx_hold_full,
  input wire logic tx_hold_take,
  input wire logic tx_shift_empty,
  // Receiver side
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic rx_parity_err,
  input wire logic rx_frame_err,
  input wire logic serial_input,
  input wire logic bit_tick,
  // Interrupts
  output logic irq_pending_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic div_access_reg, hold_full_reg, rx_ready_reg, tx_hold_empty_irq_reg;
  logic tx_hold_empty_set, break_pulse, tx_all_empty, tx_hold_empty;
  logic line_pend, rx_pend, tx_pend, overrun_hit;
  logic wr_thr, rd_rbr, rd_lsr, rd_iid, wr_ien;
  logic [7:0] tx_data_reg, rx_buf_reg, irq_en_reg, rdata_reg;
  logic [7:0] uart_line_status, uart_irq_ident;
  logic [3:0] line_err_reg, line_err_set; // break, framing, parity, overrun
  logic [3:0] evt_reg, evt_set, evt_mask_reg;
  usi_pkg::usi_iid_t iid_code;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Pick the highest pending source; shared by read data and clears
  function automatic usi_pkg::usi_iid_t iid_pick(
    input logic line_p,
    input logic rx_p,
    input logic tx_p
  );
    if (line_p)
      return usi_pkg::IID_LINE;
    else if (rx_p)
      return usi_pkg::IID_RX_FULL;
    else if (tx_p)
      return usi_pkg::IID_TX_EMPTY;
    else
      return usi_pkg::IID_NONE;
  endfunction

  // Data and enable registers vanish while divisor access is set
  assign wr_thr = reg_wr && reg_addr == usi_pkg::ADDR_TX_RX
                  && !div_access_reg;
  assign rd_rbr = reg_rd && reg_addr == usi_pkg::ADDR_TX_RX
                  && !div_access_reg;
  assign wr_ien = reg_wr && reg_addr == usi_pkg::ADDR_IRQ_EN
                  && !div_access_reg;
  assign rd_lsr = reg_rd && reg_addr == usi_pkg::ADDR_LINE_STAT;
  assign rd_iid = reg_rd && reg_addr == usi_pkg::ADDR_IRQ_ID;

  // ----------------------------------------------------------------
  // Line control: only the divisor access bit lives here
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      div_access_reg <= 1'b0;
    else if (reg_wr && reg_addr == usi_pkg::ADDR_LINE_CTRL)
      div_access_reg <= reg_wdata[usi_pkg::LC_DIV_ACCESS];
  end

  // ----------------------------------------------------------------
  // Transmit holding register
  // ----------------------------------------------------------------
  // A write in the same cycle as a take refills the holding register
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hold_full_reg <= 1'b0;
    else if (wr_thr)
      hold_full_reg <= 1'b1;
    else if (tx_hold_take)
      hold_full_reg <= 1'b0;
  end

  // Transmit data
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_data_reg <= 8'h00;
    else if (wr_thr)
      tx_data_reg <= reg_wdata;
  end

  assign tx_data = tx_data_reg;
  assign tx_hold_full = hold_full_reg;
  assign tx_hold_empty = !hold_full_reg;
  assign tx_all_empty = !hold_full_reg && tx_shift_empty;

  // ----------------------------------------------------------------
  // Receive buffer and data ready
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rx_buf_reg <= 8'h00;
    else if (rx_char_valid)
      rx_buf_reg <= rx_char;
  end

  // New character wins over a read in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rx_ready_reg <= 1'b0;
    else if (rx_char_valid)
      rx_ready_reg <= 1'b1;
    else if (rd_rbr)
      rx_ready_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Break and error flags
  // ----------------------------------------------------------------
  usi_break_det #(
    .MAX_BITS(usi_pkg::MAX_WORD_BITS)
  ) u_break (
    .clk(clk),
    .sys_rst(sys_rst),
    .serial_input(serial_input),
    .bit_tick(bit_tick),
    .break_pulse(break_pulse)
  );

  // Old data read in the same cycle is not overrun
  assign overrun_hit = rx_char_valid && rx_ready_reg && !rd_rbr;

  assign line_err_set = {break_pulse,
                         rx_char_valid && rx_frame_err,
                         rx_char_valid && rx_parity_err,
                         overrun_hit};

  // Status read clears; a flag raised in that cycle survives it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      line_err_reg <= 4'h0;
    else if (rd_lsr)
      line_err_reg <= line_err_set;
    else
      line_err_reg <= line_err_reg | line_err_set;
  end

  // Read-only image, bit 7 always zero
  assign uart_line_status = {1'b0, tx_all_empty, tx_hold_empty,
                             line_err_reg, rx_ready_reg};

  // ----------------------------------------------------------------
  // Interrupt enable
  // ----------------------------------------------------------------
  // Bits 7..3 are not stored; bit 3 is expected written as zero
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      irq_en_reg <= usi_pkg::IRQ_EN_RST;
    else if (wr_ien)
      irq_en_reg <= reg_wdata & usi_pkg::IE_WRITE_MASK;
  end

  // ----------------------------------------------------------------
  // Transmit empty interrupt source
  // ----------------------------------------------------------------
  // Raised when the holding register drains, or when the enable is
  // turned on while it is already empty
  assign tx_hold_empty_set = (tx_hold_take && hold_full_reg && !wr_thr)
                    || (wr_ien && reg_wdata[usi_pkg::IE_TX_EMPTY]
                        && !irq_en_reg[usi_pkg::IE_TX_EMPTY]
                        && !hold_full_reg);

  // Cleared by a holding write or an ident read reporting it
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_hold_empty_irq_reg <= 1'b0;
    else if (tx_hold_empty_set)
      tx_hold_empty_irq_reg <= 1'b1;
    else if (wr_thr)
      tx_hold_empty_irq_reg <= 1'b0;
    else if (rd_iid && iid_code == usi_pkg::IID_TX_EMPTY)
      tx_hold_empty_irq_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Prioritised identification
  // ----------------------------------------------------------------
  assign line_pend = irq_en_reg[usi_pkg::IE_LINE_STATUS]
                     && (|line_err_reg[2:0]);
  assign tx_pend = irq_en_reg[usi_pkg::IE_TX_EMPTY]
                   && tx_hold_empty_irq_reg && tx_hold_empty;
  assign rx_pend = irq_en_reg[usi_pkg::IE_RX_FULL]
                   && rx_ready_reg;

  assign iid_code = iid_pick(line_pend, rx_pend,
                             tx_pend);

  // Bit 0 is low while anything is pending
  assign uart_irq_ident = {5'h00, iid_code,
                           !(line_pend || rx_pend || tx_pend)};
  assign irq_pending_n = uart_irq_ident[0];

  // ----------------------------------------------------------------
  // Sticky events, mask and interrupt output
  // ----------------------------------------------------------------
  always_comb
  begin
    evt_set = 4'h0;
    evt_set[usi_pkg::EV_RX_CHAR] = rx_char_valid;
    evt_set[usi_pkg::EV_TX_EMPTY] = tx_hold_empty_set;
    evt_set[usi_pkg::EV_LINE_ERR] = |line_err_set[2:0];
    evt_set[usi_pkg::EV_BREAK] = break_pulse;
  end

  // Write one to clear; a new event in the same cycle stays set
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      evt_reg <= usi_pkg::EVT_RST;
    else if (reg_wr && reg_addr == usi_pkg::ADDR_EVT_STAT)
      evt_reg <= (evt_reg & ~reg_wdata[3:0]) | evt_set;
    else
      evt_reg <= evt_reg | evt_set;
  end

  // Mask
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      evt_mask_reg <= usi_pkg::EVT_RST;
    else if (reg_wr && reg_addr == usi_pkg::ADDR_EVT_MASK)
      evt_mask_reg <= reg_wdata[3:0];
  end

  assign irq = |(evt_reg & evt_mask_reg);

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  // Unmapped or hidden addresses read zero; idle cycles read zero too
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      rdata_reg <= 8'h00;
    else if (!reg_rd)
      rdata_reg <= 8'h00;
    else
      case (reg_addr)
        usi_pkg::ADDR_TX_RX: rdata_reg <= div_access_reg ? 8'h00 : rx_buf_reg;
        usi_pkg::ADDR_IRQ_EN: rdata_reg <= div_access_reg ? 8'h00 : irq_en_reg;
        usi_pkg::ADDR_IRQ_ID: rdata_reg <= uart_irq_ident;
        usi_pkg::ADDR_LINE_CTRL: rdata_reg <= {div_access_reg, 7'h00};
        usi_pkg::ADDR_LINE_STAT: rdata_reg <= uart_line_status;
        usi_pkg::ADDR_EVT_STAT: rdata_reg <= {4'h0, evt_reg};
        usi_pkg::ADDR_EVT_MASK: rdata_reg <= {4'h0, evt_mask_reg};
        default: rdata_reg <= 8'h00;
      endcase
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_char_in;
    rx_char_valid;
  endsequence
  sequence s_buf_read;
    rd_rbr && !rx_char_valid;
  endsequence

  chk_tx_all_empty_on_write: assert property (
    wr_thr |=> !uart_line_status[usi_pkg::LS_TX_ALL_EMPTY])
    else $error("all-empty bit still set after holding write");
  chk_tx_hold_empty_on_take: assert property (
    tx_hold_take && hold_full_reg && !wr_thr
    |=> uart_line_status[usi_pkg::LS_TX_HOLD_EMPTY] && !tx_hold_full)
    else $error("holding-empty bit not set after take");
  chk_break_flag_set: assert property (
    break_pulse |=> uart_line_status[usi_pkg::LS_BREAK])
    else $error("break flag not set");
  chk_frame_flag_set: assert property (
    rx_char_valid && rx_frame_err
    |=> uart_line_status[usi_pkg::LS_FRAMING])
    else $error("framing flag not set");
  chk_parity_flag_set: assert property (
    rx_char_valid && rx_parity_err
    |=> uart_line_status[usi_pkg::LS_PARITY])
    else $error("parity flag not set");
  chk_overrun_flag_set: assert property (
    rx_char_valid && rx_ready_reg && !rd_rbr
    |=> uart_line_status[usi_pkg::LS_OVERRUN])
    else $error("overrun flag not set");
  chk_ready_cycle: assert property (
    s_char_in ##1 s_buf_read |=> !rx_ready_reg)
    else $error("data ready not cleared by buffer read");
  chk_ready_hold: assert property (
    s_char_in ##1 !rd_rbr |-> rx_ready_reg)
    else $error("data ready lost without a read");
  chk_ident_idle: assert property (
    !line_pend && !rx_pend && !tx_pend |-> uart_irq_ident == 8'h01)
    else $error("idle identification not 0x01");
  chk_line_first: assert property (
    line_pend |-> iid_code == usi_pkg::IID_LINE && !irq_pending_n)
    else $error("line status not reported first");
  chk_rx_second: assert property (
    rx_pend && !line_pend |-> iid_code == usi_pkg::IID_RX_FULL)
    else $error("receive full not reported second");
  chk_ident_clears_tx: assert property (
    rd_iid && iid_code == usi_pkg::IID_TX_EMPTY && !tx_hold_empty_set
    |=> !tx_hold_empty_irq_reg)
    else $error("ident read did not clear transmit source");
  chk_status_read_clr: assert property (
    rd_lsr && line_err_set == 4'h0 |=> line_err_reg == 4'h0)
    else $error("status read did not clear error flags");
  chk_status_latency: assert property (
    rd_lsr |=> reg_rdata == $past(uart_line_status) && !reg_rdata[7])
    else $error("status read data wrong or late");
  // A character landing in the same cycle may legally set data ready
  chk_div_hides_buf: assert property (
    reg_rd && reg_addr == usi_pkg::ADDR_TX_RX && div_access_reg
    && !rx_char_valid |=> reg_rdata == 8'h00 && $stable(rx_ready_reg))
    else $error("buffer reachable during divisor access");
endmodule

// ---- testbench/usi_line_model.sv ----
// Line model: the transmitter and receiver beside the status block.
// Assumes the bench steers it through level and pulse commands.
`timescale 1ns/1ns
module usi_line_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bench commands
  input wire logic take_en,
  input wire logic rx_go,
  input wire logic [7:0] rx_byte,
  input wire logic rx_pe,
  input wire logic rx_fe,
  input wire logic line_low,
  // Status block side
  input wire logic tx_hold_full,
  output logic tx_hold_take,
  output logic tx_shift_empty,
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic rx_parity_err,
  output logic rx_frame_err,
  output logic serial_input,
  output logic bit_tick
);
  logic [3:0] shift_cnt;
  logic [1:0] tick_cnt;

  // Bit time of four clocks keeps the break wait short; data lines
  // toggle when not qualified so a stale value cannot pass for data
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tick_cnt <= 2'h0;
      bit_tick <= 1'b0;
      rx_char_valid <= 1'b0;
      rx_char <= 8'h00;
      rx_parity_err <= 1'b0;
      rx_frame_err <= 1'b0;
      serial_input <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 2'h1;
      bit_tick <= (tick_cnt == 2'h3);
      rx_char_valid <= rx_go;
      rx_char <= rx_go ? rx_byte : ~rx_char;
      rx_parity_err <= rx_go ? rx_pe : ~rx_parity_err;
      rx_frame_err <= rx_go ? rx_fe : ~rx_frame_err;
      serial_input <= !line_low;
    end
  end

  // Take only when the shifter is idle, so a stall keeps data held
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_hold_take <= 1'b0;
      shift_cnt <= 4'h0;
    end
    else
    begin
      tx_hold_take <= take_en && tx_hold_full && !tx_hold_take &&
        shift_cnt == 4'h0;
      if (tx_hold_take)
        shift_cnt <= 4'h8;
      else if (shift_cnt != 4'h0)
        shift_cnt <= shift_cnt - 4'h1;
    end
  end

  assign tx_shift_empty = (shift_cnt == 4'h0);
endmodule

// ---- testbench/test_uart_status_and_interrupt.sv ----
// Testbench for the UART status and interrupt identification block.
// Assumes usi_top and the line model; read data checked a cycle on.
`timescale 1ns/1ns
module test_uart_status_and_interrupt;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic take_en = 1'b0;
  logic rx_go = 1'b0;
  logic rx_pe = 1'b0;
  logic rx_fe = 1'b0;
  logic line_low = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] reg_rdata, tx_data, rx_char, b1, b2, e;
  logic tx_hold_full, tx_hold_take, tx_shift_empty, rx_char_valid;
  logic rx_parity_err, rx_frame_err, serial_input, bit_tick;
  logic irq_pending_n, irq, rd_seen, a;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int total_checks = 0;
  int seed = 74;

  usi_top u_dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_data, .tx_hold_full, .tx_hold_take,
    .tx_shift_empty, .rx_char_valid, .rx_char, .rx_parity_err,
    .rx_frame_err, .serial_input, .bit_tick, .irq_pending_n, .irq);
  usi_line_model u_line (.clk, .sys_rst, .take_en, .rx_go, .rx_byte,
    .rx_pe, .rx_fe, .line_low, .tx_hold_full, .tx_hold_take,
    .tx_shift_empty, .rx_char_valid, .rx_char, .rx_parity_err,
    .rx_frame_err, .serial_input, .bit_tick);

  initial
    forever #4 clk = ~clk;

  // ----------------------------------------------------------------
  // Reporting
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic fail(input string m);
    n_fail++;
    $display("wrong value at %0t: %s", $time, m);
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
      fail($sformatf("got %h expected %h", got, exp));
  endtask

  // ----------------------------------------------------------------
  // Drivers; each ends 1 ns past the edge so outputs have settled
  // ----------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [31:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // The expectation is queued before the strobe goes out
  task automatic rd(input logic [31:0] ad, input logic [7:0] x);
    exp_q.push_back(x);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
  endtask

  task automatic rx_pulse(input logic [7:0] d, input logic p,
    input logic f);
    @(posedge clk);
    rx_byte <= d;
    rx_pe <= p;
    rx_fe <= f;
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
    idle(2);
  endtask

  task automatic wait_taken();
    for (int i = 0; i < 50; i++)
    begin
      idle(1);
      if (tx_hold_full === 1'b0)
        return;
    end
    fail("holding register never taken");
    print_verdict();
  endtask

  // Read data stands only in the cycle after the strobe, else zero
  always @(posedge clk)
    rd_seen <= reg_rd;
  always @(negedge clk)
  begin
    if (rd_seen === 1'b1)
    begin
      e = exp_q.pop_front();
      chk(reg_rdata, e);
    end
    else if (!sys_rst && reg_rdata !== 8'h00)
      fail("read data outside its cycle");
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    fail("run timed out");
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    idle(1);
    chk({7'h0, irq_pending_n}, 8'h01);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h60);
    rd(usi_pkg::ADDR_IRQ_EN, 8'h00);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h01);
    wr(usi_pkg::ADDR_LINE_STAT, 8'hff);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h60);
    rd(32'hffff0718, 8'h00);
    $display("test reset done");
    // Bit 3 kept zero; empty holding raises the transmit source
    wr(usi_pkg::ADDR_IRQ_EN, 8'h07);
    rd(usi_pkg::ADDR_IRQ_EN, 8'h07);
    chk({7'h0, irq_pending_n}, 8'h00);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h02);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h01);
    $display("test enable done");
    // Transmit with the shifter stalled, then released
    b1 = 8'($random(seed));
    wr(usi_pkg::ADDR_TX_RX, b1);
    chk(tx_data, b1);
    chk({7'h0, tx_hold_full}, 8'h01);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h00);
    take_en <= 1'b1;
    wait_taken();
    rd(usi_pkg::ADDR_LINE_STAT, 8'h20);
    take_en <= 1'b0;
    wr(usi_pkg::ADDR_TX_RX, b1 ^ 8'h5a);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h01);
    take_en <= 1'b1;
    wait_taken();
    idle(10);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h60);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h02);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h01);
    $display("test transmit done");
    // Plain receive
    b1 = 8'($random(seed));
    rx_pulse(b1, 1'b0, 1'b0);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h61);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h04);
    rd(usi_pkg::ADDR_TX_RX, b1);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h60);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h01);
    $display("test receive done");
    // Overrun with parity and framing faults, line enable gated
    wr(usi_pkg::ADDR_IRQ_EN, 8'h03);
    b2 = 8'($random(seed));
    rx_pulse(b1, 1'b0, 1'b0);
    rx_pulse(b2, 1'b1, 1'b1);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h04);
    wr(usi_pkg::ADDR_IRQ_EN, 8'h07);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h06);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h6f);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h61);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h04);
    rd(usi_pkg::ADDR_TX_RX, b2);
    $display("test errors done");
    // Break: 70 clocks is over 13 bit times of four clocks
    line_low <= 1'b1;
    idle(70);
    line_low <= 1'b0;
    idle(2);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h70);
    rd(usi_pkg::ADDR_IRQ_ID, 8'h01);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h60);
    $display("test break done");
    // Sticky events, one mask setting must pass them, the other not
    wr(usi_pkg::ADDR_EVT_STAT, 8'h0f);
    rd(usi_pkg::ADDR_EVT_STAT, 8'h00);
    rx_pulse(b1, 1'b0, 1'b0);
    rd(usi_pkg::ADDR_EVT_STAT, 8'h01);
    wr(usi_pkg::ADDR_EVT_MASK, 8'h00);
    a = irq;
    wr(usi_pkg::ADDR_EVT_MASK, 8'h0f);
    chk({7'h0, a ^ irq}, 8'h01);
    wr(usi_pkg::ADDR_EVT_STAT, 8'h01);
    chk({7'h0, irq}, 8'h00);
    rd(usi_pkg::ADDR_TX_RX, b1);
    $display("test events done");
    // Divisor access steers data and enable away
    take_en <= 1'b0;
    wr(usi_pkg::ADDR_LINE_CTRL, 8'h80);
    rd(usi_pkg::ADDR_LINE_CTRL, 8'h80);
    rd(usi_pkg::ADDR_IRQ_EN, 8'h00);
    wr(usi_pkg::ADDR_TX_RX, 8'h33);
    chk({7'h0, tx_hold_full}, 8'h00);
    // A hidden buffer read must neither show data nor clear data ready
    rx_pulse(b2, 1'b0, 1'b0);
    rd(usi_pkg::ADDR_TX_RX, 8'h00);
    wr(usi_pkg::ADDR_LINE_CTRL, 8'h00);
    rd(usi_pkg::ADDR_IRQ_EN, 8'h07);
    rd(usi_pkg::ADDR_LINE_STAT, 8'h61);
    rd(usi_pkg::ADDR_TX_RX, b2);
    $display("test divisor done");
    idle(3);
    if (exp_q.size() != 0)
      fail("reads left unanswered");
    print_verdict();
  end
endmodule
